// >>> scd_regs.svh
// constants for the spi-mode command decoder
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

`define SCD_FRAME_W      48
`define SCD_FRAME_LAST   6'h2f
`define SCD_START_BIT    47
`define SCD_TX_BIT       46
`define SCD_IDX_HI       45
`define SCD_IDX_LO       40
`define SCD_ARG_HI       39
`define SCD_ARG_LO       8
`define SCD_CRC_HI       7
`define SCD_CRC_LO       1
`define SCD_END_BIT      0
`define SCD_CRC_POLY     7'h09

`define SCD_SW_ACC_HI    25
`define SCD_SW_ACC_LO    24
`define SCD_SW_IDX_HI    23
`define SCD_SW_IDX_LO    16
`define SCD_SW_VAL_HI    15
`define SCD_SW_VAL_LO    8
`define SCD_SW_SET_HI    2
`define SCD_SW_SET_LO    0
`define SCD_CNT_HI       15
`define SCD_CNT_LO       0

`define SCD_ACC_CMDSET   2'h0
`define SCD_ACC_SETBITS  2'h1
`define SCD_ACC_CLRBITS  2'h2
`define SCD_ACC_WRBYTE   2'h3

`define SCD_CMD_RESET    6'h00
`define SCD_CMD_INIT     6'h01
`define SCD_CMD_SWITCH   6'h06
`define SCD_CMD_EXT      6'h08
`define SCD_CMD_CSD      6'h09
`define SCD_CMD_CID      6'h0a
`define SCD_CMD_STOP     6'h0c
`define SCD_CMD_STATUS   6'h0d
`define SCD_CMD_BLKLEN   6'h10
`define SCD_CMD_RDSINGLE 6'h11
`define SCD_CMD_RDMULTI  6'h12
`define SCD_CMD_BLKCNT   6'h17
`define SCD_CMD_FIRST_EXT 6'h18

`define SCD_CLASSES      12'h1f5
`define SCD_BLKLEN_RST   32'h00000200
`define SCD_BUSW_BYTE    8'h00
`define SCD_BUSW_ONEBIT  8'h00

`endif

// >>> scd_pkg.sv
// types shared by the spi-mode command decoder
package scd_pkg;

  typedef enum logic [1:0] {
    SCD_RESP_SHORT      = 2'h0,
    SCD_RESP_SHORT_BUSY = 2'h1,
    SCD_RESP_TWO_BYTE   = 2'h2
  } scd_resp_kind_t;

  typedef enum logic [0:0] {
    SCD_RX_IDLE  = 1'h0,
    SCD_RX_SHIFT = 1'h1
  } scd_rx_state_t;

  typedef struct packed {
    logic           idle;
    logic           illegal;
    logic           crc_fail;
    scd_resp_kind_t kind;
  } scd_resp_t;

  typedef struct packed {
    logic [1:0] access;
    logic [7:0] index;
    logic [7:0] value;
    logic [2:0] cmd_set;
  } scd_switch_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] blk_len;
    logic [15:0] count;
    logic        open_ended;
    logic        multi;
  } scd_read_t;

endpackage

// >>> scd_decoder.sv
// spi-mode command frame receiver and decoder
//
// Behaviour
// [R01] only supported indices pass; 2,3,4,7,11,15,20 unsupported
// [R02] host zeroes the argument of commands that take none
// [R03] reserved indices 5,21,22 handled as in native mode, as reserved
// [R04] command class field stays a valid list of supported classes
// [R05] index field holds the binary command number
// [R06] cmd 0 resets card, cmd 1 starts init; both short response
// [R07] switch argument split into access, byte index, value, command set
// [R08] access 00 command set, 01 set bits, 10 clear bits, 11 write byte
// [R09] switch works as native except bus width stays one bit
// [R10] cmd 8 answers short then sends extended registers as one block
// [R11] cmd 9 sends specific data, cmd 10 identification; short response
// [R12] cmd 12 ends a multiple-block read; short response
// [R13] cmd 13 answers with two-byte status response
// [R14] indices 14 and 19 are illegal in this mode
// [R15] cmd 16 stores 32-bit block length for later block commands
// [R16] cmd 17 reads one block of stored length at argument address
// [R17] cmd 18 streams blocks until stop command or preset count done
// [R18] cmd 23 count in bits 15:0, used by next multiple transfer only
// [R19] zero block count makes next multiple transfer open-ended
// [R20] 48-bit frame msb first: start 0, tx 1, index, argument, check, end 1
// [R21] illegal command and failed check set their response flags
// [R22] unsupported or reserved indices flag illegal and change nothing
// [R23] consumed block count returns to open-ended state
`timescale 1ns/10ps
`default_nettype none
`include "scd_regs.svh"

module scd_decoder #(
  parameter logic [31:0] BLKLEN_RESET = `SCD_BLKLEN_RST,
  parameter logic [7:0]  BUSW_BYTE    = `SCD_BUSW_BYTE,
  parameter int          COUNT_W      = 16
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               LINK_CLK,
  input  wire logic               CS_N,
  input  wire logic               MOSI,
  input  wire logic               CRC_CHECK_EN,
  input  wire logic               BLOCK_SENT,
  output logic                    RESP_VALID,
  output scd_pkg::scd_resp_t      RESP,
  output logic                    DO_RESET,
  output logic                    DO_INIT,
  output logic                    SEND_EXT_REGS,
  output logic                    SEND_SPECIFIC,
  output logic                    SEND_IDENT,
  output logic                    SEND_STATUS,
  output logic                    SWITCH_APPLY,
  output logic                    SWITCH_BLOCKED,
  output scd_pkg::scd_switch_t    SWITCH_REQ,
  output logic                    READ_START,
  output scd_pkg::scd_read_t      READ_REQ,
  output logic                    READ_ACTIVE,
  output logic                    READ_STOP,
  output logic                    OTHER_CMD,
  output logic [5:0]              OTHER_INDEX,
  output logic [31:0]             OTHER_ARG,
  output logic [11:0]             CMD_CLASSES
);

  // refuse widths and values the logic cannot serve
  if (COUNT_W != `SCD_CNT_HI - `SCD_CNT_LO + 1) begin
    $error("COUNT_W must match the block count field");
  end
  if (BLKLEN_RESET == 32'h00000000) begin
    $error("BLKLEN_RESET must not be zero");
  end

  function automatic logic [6:0] seven_bit_check(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = c[6] ^ d[i];
      c = {c[5:0], 1'b0};
      if (fb) c = c ^ `SCD_CRC_POLY;
    end
    return c;
  endfunction

  function automatic logic is_illegal(input logic [5:0] idx);
    case (idx)
      6'h02, 6'h03, 6'h04, 6'h07, 6'h0b, 6'h0f, 6'h14: return 1'b1; // [R01]
      6'h05, 6'h15, 6'h16: return 1'b1; // [R03]
      6'h0e, 6'h13: return 1'b1; // [R14]
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link domain: frame receiver

  logic                  l_rst1_reg;
  logic                  l_rst2_reg;
  scd_pkg::scd_rx_state_t l_state_reg;
  logic [5:0]            l_cnt_reg;
  logic [46:0]           l_sh_reg;
  logic [47:0]           l_frame_reg;
  logic                  l_tog_reg;
  wire                   l_rst = ~l_rst2_reg;
  wire                   l_last = (l_cnt_reg == `SCD_FRAME_LAST);
  wire                   l_begin = ~CS_N & ~MOSI;
  wire                   l_done = (l_state_reg == scd_pkg::SCD_RX_SHIFT) & l_last & ~CS_N;

  // reset reaches the link side two link edges late
  always_ff @(posedge LINK_CLK) begin
    l_rst1_reg <= RST_N;
    l_rst2_reg <= l_rst1_reg;
  end

  // msb first, start bit 0 opens the frame
  always_ff @(posedge LINK_CLK) begin
    if (l_rst || CS_N) begin
      l_state_reg <= scd_pkg::SCD_RX_IDLE;
      l_cnt_reg   <= 6'h00;
    end else begin
      case (l_state_reg)
        scd_pkg::SCD_RX_IDLE: begin
          if (l_begin) begin
            l_state_reg <= scd_pkg::SCD_RX_SHIFT; // [R20]
            l_cnt_reg   <= 6'h01;
          end
        end
        scd_pkg::SCD_RX_SHIFT: begin
          l_cnt_reg <= l_cnt_reg + 6'h01;
          if (l_last) l_state_reg <= scd_pkg::SCD_RX_IDLE;
        end
        default: l_state_reg <= scd_pkg::SCD_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (l_rst) begin
      l_sh_reg    <= 47'h0;
      l_frame_reg <= 48'h0;
      l_tog_reg   <= 1'b0;
    end else begin
      l_sh_reg <= {l_sh_reg[45:0], MOSI};
      if (l_done) begin
        l_frame_reg <= {l_sh_reg, MOSI}; // [R20]
        l_tog_reg   <= ~l_tog_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing: toggle event, frame held stable for a whole frame time

  logic        s1_reg;
  logic        s2_reg;
  logic        s3_reg;
  logic [47:0] frame_reg;
  logic        fresh_reg;
  wire         frame_evt = s2_reg ^ s3_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      frame_reg <= 48'h0;
      fresh_reg <= 1'b0;
    end else begin
      s1_reg    <= l_tog_reg;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      fresh_reg <= frame_evt;
      if (frame_evt) frame_reg <= l_frame_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire [5:0]  idx = frame_reg[`SCD_IDX_HI:`SCD_IDX_LO]; // [R05]
  wire [31:0] arg = frame_reg[`SCD_ARG_HI:`SCD_ARG_LO];
  wire        framed = ~frame_reg[`SCD_START_BIT] & frame_reg[`SCD_TX_BIT]
                       & frame_reg[`SCD_END_BIT];
  wire        crc_bad = CRC_CHECK_EN &
                        (seven_bit_check(frame_reg[`SCD_START_BIT:`SCD_ARG_LO])
                         != frame_reg[`SCD_CRC_HI:`SCD_CRC_LO]);
  wire        cmd = fresh_reg & framed;
  wire        ext = idx >= `SCD_CMD_FIRST_EXT;
  wire        bad = is_illegal(idx);
  wire        ok = cmd & ~crc_bad & ~bad; // [R22]
  wire        mine = ok & ~ext;
  wire        hit_reset = mine & (idx == `SCD_CMD_RESET);
  wire        hit_init = mine & (idx == `SCD_CMD_INIT);
  wire        hit_switch = mine & (idx == `SCD_CMD_SWITCH);
  wire        hit_ext = mine & (idx == `SCD_CMD_EXT);
  wire        hit_csd = mine & (idx == `SCD_CMD_CSD);
  wire        hit_cid = mine & (idx == `SCD_CMD_CID);
  wire        hit_stop = mine & (idx == `SCD_CMD_STOP);
  wire        hit_status = mine & (idx == `SCD_CMD_STATUS);
  wire        hit_blklen = mine & (idx == `SCD_CMD_BLKLEN);
  wire        hit_rd1 = mine & (idx == `SCD_CMD_RDSINGLE);
  wire        hit_rdn = mine & (idx == `SCD_CMD_RDMULTI);
  wire        hit_blkcnt = mine & (idx == `SCD_CMD_BLKCNT);
  wire        rd_any = hit_rd1 | hit_rdn;

  scd_pkg::scd_switch_t sw;
  assign sw = '{
    access:  arg[`SCD_SW_ACC_HI:`SCD_SW_ACC_LO], // [R07]
    index:   arg[`SCD_SW_IDX_HI:`SCD_SW_IDX_LO],
    value:   arg[`SCD_SW_VAL_HI:`SCD_SW_VAL_LO],
    cmd_set: arg[`SCD_SW_SET_HI:`SCD_SW_SET_LO]
  };

  // any access other than command-set that would widen the bus is held off
  wire sw_busw = (sw.access != `SCD_ACC_CMDSET) & (sw.index == BUSW_BYTE); // [R08]
  wire sw_block = sw_busw & (sw.value != `SCD_BUSW_ONEBIT); // [R09]

  wire resp_any = cmd & (~ok | ~ext);
  scd_pkg::scd_resp_kind_t kind_next;
  assign kind_next = hit_status ? scd_pkg::SCD_RESP_TWO_BYTE : // [R13]
                     hit_switch ? scd_pkg::SCD_RESP_SHORT_BUSY : // [R07]
                     scd_pkg::SCD_RESP_SHORT; // [R06]

  ////////////////////////////////////////////////////////////////////////
  // card state

  logic                    idle_reg;
  logic [31:0]             blklen_reg;
  logic [COUNT_W-1:0]      cnt_reg;
  logic                    act_reg;
  logic [COUNT_W-1:0]      left_reg;
  logic                    open_reg;
  wire  [COUNT_W-1:0]      left_dec = left_reg - {{(COUNT_W-1){1'b0}}, 1'b1};
  wire                     cnt_zero = (cnt_reg == {COUNT_W{1'b0}});
  wire                     blk_step = act_reg & ~open_reg & BLOCK_SENT;
  wire                     count_done = blk_step & (left_dec == {COUNT_W{1'b0}});

  always_ff @(posedge CLK) begin
    if (!RST_N || hit_reset) begin
      idle_reg   <= 1'b1; // [R06]
      blklen_reg <= BLKLEN_RESET;
      cnt_reg    <= {COUNT_W{1'b0}};
    end else begin
      if (hit_init) idle_reg <= 1'b0; // [R06]
      if (hit_blklen) blklen_reg <= arg; // [R15]
      if (hit_blkcnt) cnt_reg <= arg[`SCD_CNT_HI:`SCD_CNT_LO]; // [R18]
      else if (hit_rdn) cnt_reg <= {COUNT_W{1'b0}}; // [R23]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N || hit_reset) begin
      act_reg  <= 1'b0;
      left_reg <= {COUNT_W{1'b0}};
      open_reg <= 1'b0;
    end else if (hit_rdn) begin
      act_reg  <= 1'b1; // [R17]
      left_reg <= cnt_reg;
      open_reg <= cnt_zero; // [R19]
    end else if (hit_stop || count_done) begin
      act_reg <= 1'b0; // [R12]
    end else if (blk_step) begin
      left_reg <= left_dec; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RESP_VALID <= 1'b0;
      RESP       <= '0;
    end else begin
      RESP_VALID    <= resp_any;
      RESP.idle     <= hit_reset | (idle_reg & ~hit_init);
      RESP.illegal  <= cmd & ~crc_bad & bad; // [R21]
      RESP.crc_fail <= cmd & crc_bad; // [R21]
      RESP.kind     <= kind_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DO_RESET      <= 1'b0;
      DO_INIT       <= 1'b0;
      SEND_EXT_REGS <= 1'b0;
      SEND_SPECIFIC <= 1'b0;
      SEND_IDENT    <= 1'b0;
      SEND_STATUS   <= 1'b0;
      READ_STOP     <= 1'b0;
      OTHER_CMD     <= 1'b0;
    end else begin
      DO_RESET      <= hit_reset; // [R06]
      DO_INIT       <= hit_init; // [R06]
      SEND_EXT_REGS <= hit_ext; // [R10]
      SEND_SPECIFIC <= hit_csd; // [R11]
      SEND_IDENT    <= hit_cid; // [R11]
      SEND_STATUS   <= hit_status; // [R13]
      READ_STOP     <= (hit_stop & act_reg) | count_done; // [R12]
      OTHER_CMD     <= ok & ext;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SWITCH_APPLY   <= 1'b0;
      SWITCH_BLOCKED <= 1'b0;
      SWITCH_REQ     <= '0;
    end else begin
      SWITCH_APPLY   <= hit_switch & ~sw_block; // [R09]
      SWITCH_BLOCKED <= hit_switch & sw_block;
      if (hit_switch) SWITCH_REQ <= sw; // [R08]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      READ_START  <= 1'b0;
      READ_REQ    <= '0;
      OTHER_INDEX <= 6'h00;
      OTHER_ARG   <= 32'h0;
    end else begin
      READ_START <= rd_any; // [R16]
      if (rd_any) begin
        READ_REQ.addr       <= arg; // [R16]
        READ_REQ.blk_len    <= blklen_reg; // [R15]
        READ_REQ.count      <= hit_rdn ? cnt_reg : {{(COUNT_W-1){1'b0}}, 1'b1};
        READ_REQ.open_ended <= hit_rdn & cnt_zero; // [R19]
        READ_REQ.multi      <= hit_rdn; // [R17]
      end
      if (ok && ext) begin
        OTHER_INDEX <= idx;
        OTHER_ARG   <= arg;
      end
    end
  end

  assign READ_ACTIVE = act_reg;
  assign CMD_CLASSES = `SCD_CLASSES; // [R04]

endmodule
`default_nettype wire

// >>> scd_decoder_asserts.sv
// concurrent checks on the command decoder ports
`timescale 1ns/10ps
`default_nettype none
`include "scd_regs.svh"
module scd_decoder_asserts #(
  parameter logic [7:0] BUSW_BYTE = `SCD_BUSW_BYTE
) (
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic                 RESP_VALID,
  input wire scd_pkg::scd_resp_t   RESP,
  input wire logic                 DO_RESET,
  input wire logic                 DO_INIT,
  input wire logic                 SEND_EXT_REGS,
  input wire logic                 SEND_SPECIFIC,
  input wire logic                 SEND_IDENT,
  input wire logic                 SEND_STATUS,
  input wire logic                 SWITCH_APPLY,
  input wire logic                 SWITCH_BLOCKED,
  input wire scd_pkg::scd_switch_t SWITCH_REQ,
  input wire logic                 READ_START,
  input wire scd_pkg::scd_read_t   READ_REQ,
  input wire logic                 READ_ACTIVE,
  input wire logic                 READ_STOP,
  input wire logic                 OTHER_CMD,
  input wire logic [5:0]           OTHER_INDEX,
  input wire logic [11:0]          CMD_CLASSES
);
  wire logic [9:0] acts;
  assign acts = {DO_RESET, DO_INIT, SEND_EXT_REGS, SEND_SPECIFIC, SEND_IDENT,
                 SEND_STATUS, SWITCH_APPLY, SWITCH_BLOCKED, READ_START, READ_STOP};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////////////////////////////////
  reset_resp_a: assert property (DO_RESET |-> RESP_VALID && RESP.idle &&
    RESP.kind == scd_pkg::SCD_RESP_SHORT) else $error("reset answer wrong");
  status_resp_a: assert property (SEND_STATUS |-> RESP_VALID &&
    RESP.kind == scd_pkg::SCD_RESP_TWO_BYTE) else $error("status answer wrong");
  switch_busy_a: assert property ((SWITCH_APPLY || SWITCH_BLOCKED) |-> RESP_VALID &&
    RESP.kind == scd_pkg::SCD_RESP_SHORT_BUSY) else $error("switch answer wrong");
  bus_width_a: assert property (SWITCH_APPLY |-> !(SWITCH_REQ.access != 2'h0 &&
    SWITCH_REQ.index == BUSW_BYTE && SWITCH_REQ.value != 8'h00))
    else $error("bus width switch applied");
  illegal_quiet_a: assert property (RESP_VALID && (RESP.illegal || RESP.crc_fail)
    |-> acts == 10'h000) else $error("action on refused command");
  classes_fixed_a: assert property (CMD_CLASSES == 12'h1f5)
    else $error("class field wrong");
  stop_ends_a: assert property (READ_STOP |=> !READ_ACTIVE)
    else $error("read still active after stop");
  single_count_a: assert property (READ_START && !READ_REQ.multi |->
    READ_REQ.count == 16'h0001) else $error("single read count wrong");
  open_end_a: assert property (READ_START && READ_REQ.multi |->
    READ_REQ.open_ended == (READ_REQ.count == 16'h0000) ##1 READ_ACTIVE)
    else $error("multi read start wrong");
  other_quiet_a: assert property (OTHER_CMD |-> !RESP_VALID &&
    OTHER_INDEX >= 6'h18) else $error("passed-out command wrong");
  cover property (READ_STOP && !RESP_VALID);
  cover property (SWITCH_BLOCKED);
  cover property (RESP_VALID && RESP.crc_fail);
endmodule
bind scd_decoder scd_decoder_asserts #(.BUSW_BYTE(BUSW_BYTE)) u_asserts (
  .CLK(CLK), .RST_N(RST_N), .RESP_VALID(RESP_VALID), .RESP(RESP),
  .DO_RESET(DO_RESET), .DO_INIT(DO_INIT), .SEND_EXT_REGS(SEND_EXT_REGS),
  .SEND_SPECIFIC(SEND_SPECIFIC), .SEND_IDENT(SEND_IDENT), .SEND_STATUS(SEND_STATUS),
  .SWITCH_APPLY(SWITCH_APPLY), .SWITCH_BLOCKED(SWITCH_BLOCKED), .SWITCH_REQ(SWITCH_REQ),
  .READ_START(READ_START), .READ_REQ(READ_REQ), .READ_ACTIVE(READ_ACTIVE),
  .READ_STOP(READ_STOP), .OTHER_CMD(OTHER_CMD), .OTHER_INDEX(OTHER_INDEX),
  .CMD_CLASSES(CMD_CLASSES));
`default_nettype wire

// >>> scd_host_model.sv
// host side of the serial link: clock, select and command frames
`timescale 1ns/10ps
`default_nettype none
module scd_host_model (
  output logic LINK_CLK,
  output logic CS_N,
  output logic MOSI
);
  initial begin
    LINK_CLK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // clock edges with card deselected
  task automatic pulse(input int n);
    repeat (n) begin
      #80 LINK_CLK = 1'b1;
      #80 LINK_CLK = 1'b0;
    end
  endtask
  // bad 1: wrong check bits, bad 2: end bit low
  task automatic send(input logic [5:0] idx, input logic [31:0] arg, input int bad);
    logic [47:0] f;
    logic [6:0] c;
    logic fb;
    f = {2'b01, idx, arg, 8'h01};
    c = 7'h00;
    for (int i = 47; i >= 8; i--) begin
      fb = f[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    f[7:1] = (bad == 1) ? ~c : c;
    if (bad == 2) f[0] = 1'b0;
    #37 CS_N = 1'b0;
    for (int i = 47; i >= 0; i--) begin
      MOSI = f[i];
      #80 LINK_CLK = 1'b1;
      #80 LINK_CLK = 1'b0;
    end
    CS_N = 1'b1;
    MOSI = ~f[0];
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] BUSW = 8'h00;
  localparam logic [3:0] K_S = 4'h0, K_B = 4'h1, K_T = 4'h2, K_C = 4'h4, K_I = 4'h8;
  logic CLK, RST_N, CRC_CHECK_EN, BLOCK_SENT, RESP_VALID, READ_ACTIVE;
  wire logic LINK_CLK, CS_N, MOSI;
  logic DO_RESET, DO_INIT, SEND_EXT_REGS, SEND_SPECIFIC, SEND_IDENT, SEND_STATUS;
  logic SWITCH_APPLY, SWITCH_BLOCKED, READ_START, READ_STOP, OTHER_CMD;
  logic [5:0] OTHER_INDEX;
  logic [31:0] OTHER_ARG;
  logic [11:0] CMD_CLASSES;
  scd_pkg::scd_resp_t RESP, rsp;
  scd_pkg::scd_switch_t SWITCH_REQ;
  scd_pkg::scd_read_t READ_REQ;
  logic [10:0] acc = '0;
  int nresp = 0, n_errors = 0, n_compared = 0, cycles = 0;
  logic [5:0] bad_idx [12] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h0b, 6'h0e, 6'h0f,
                               6'h13, 6'h14, 6'h15, 6'h16};
  wire logic [10:0] pulses;
  assign pulses = {DO_RESET, DO_INIT, SEND_EXT_REGS, SEND_SPECIFIC, SEND_IDENT, SEND_STATUS,
                   SWITCH_APPLY, SWITCH_BLOCKED, READ_START, READ_STOP, OTHER_CMD};
  scd_host_model host (.LINK_CLK(LINK_CLK), .CS_N(CS_N), .MOSI(MOSI));
  scd_decoder #(.BUSW_BYTE(BUSW)) uut (
    .CLK(CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .CS_N(CS_N), .MOSI(MOSI),
    .CRC_CHECK_EN(CRC_CHECK_EN), .BLOCK_SENT(BLOCK_SENT), .RESP_VALID(RESP_VALID),
    .RESP(RESP), .DO_RESET(DO_RESET), .DO_INIT(DO_INIT), .SEND_EXT_REGS(SEND_EXT_REGS),
    .SEND_SPECIFIC(SEND_SPECIFIC), .SEND_IDENT(SEND_IDENT), .SEND_STATUS(SEND_STATUS),
    .SWITCH_APPLY(SWITCH_APPLY), .SWITCH_BLOCKED(SWITCH_BLOCKED), .SWITCH_REQ(SWITCH_REQ),
    .READ_START(READ_START), .READ_REQ(READ_REQ), .READ_ACTIVE(READ_ACTIVE),
    .READ_STOP(READ_STOP), .OTHER_CMD(OTHER_CMD), .OTHER_INDEX(OTHER_INDEX),
    .OTHER_ARG(OTHER_ARG), .CMD_CLASSES(CMD_CLASSES));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    acc <= acc | pulses;
    if (RESP_VALID === 1'b1) begin
      nresp <= nresp + 1;
      rsp <= RESP;
    end
    if (cycles == 80000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic run(input logic [5:0] idx, input logic [31:0] arg, input int bad,
                     input logic [10:0] ep, input int en, input logic [3:0] er);
    acc = '0;
    nresp = 0;
    host.send(idx, arg, bad);
    repeat (8) @(posedge CLK);
    #1;
    chk(acc, ep);
    chk(nresp, en);
    if (en != 0) chk({rsp.illegal, rsp.crc_fail, rsp.kind}, er);
  endtask
  task automatic blk();
    acc = '0;
    BLOCK_SENT = 1'b1;
    @(posedge CLK);
    #1 BLOCK_SENT = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_basic();
    run(6'h00, 32'h0, 0, 11'h400, 1, K_S);
    chk(rsp.idle, 1'b1);
    run(6'h01, 32'h0, 0, 11'h200, 1, K_S);
    chk(rsp.idle, 1'b0);
    run(6'h08, 32'ha5a5c3c3, 0, 11'h100, 1, K_S);
    run(6'h09, 32'h0, 0, 11'h080, 1, K_S);
    run(6'h0a, 32'h0, 0, 11'h040, 1, K_S);
    run(6'h0d, 32'h0, 0, 11'h020, 1, K_T);
  endtask
  task automatic sc_illegal();
    foreach (bad_idx[i]) run(bad_idx[i], 32'hffffffff, 0, 11'h000, 1, K_I);
  endtask
  task automatic sc_blocks();
    run(6'h11, 32'h12345678, 0, 11'h004, 1, K_S);
    chk(READ_REQ, {32'h12345678, 32'h200, 16'h1, 2'b00});
    run(6'h10, 32'h00000080, 0, 11'h000, 1, K_S);
    run(6'h11, 32'hfffffe00, 0, 11'h004, 1, K_S);
    chk(READ_REQ, {32'hfffffe00, 32'h80, 16'h1, 2'b00});
  endtask
  task automatic sc_multi();
    run(6'h17, 32'h00000002, 0, 11'h000, 1, K_S);
    run(6'h12, 32'h00000100, 0, 11'h004, 1, K_S);
    chk(READ_REQ, {32'h100, 32'h80, 16'h2, 2'b01});
    chk(READ_ACTIVE, 1'b1);
    blk();
    chk(acc, 11'h000);
    blk();
    chk(acc, 11'h002);
    chk(READ_ACTIVE, 1'b0);
    run(6'h12, 32'h00000200, 0, 11'h004, 1, K_S);
    chk(READ_REQ, {32'h200, 32'h80, 16'h0, 2'b11});
    blk();
    chk(READ_ACTIVE, 1'b1);
    run(6'h0c, 32'h0, 0, 11'h002, 1, K_S);
    chk(READ_ACTIVE, 1'b0);
  endtask
  task automatic sc_switch();
    for (int a = 0; a < 4; a++) begin
      run(6'h06, {6'h0, a[1:0], 16'h205a, 8'h03}, 0, 11'h010, 1, K_B);
      chk(SWITCH_REQ, {a[1:0], 16'h205a, 3'h3});
    end
    run(6'h06, {6'h0, 2'h3, BUSW, 16'h0100}, 0, 11'h008, 1, K_B);
  endtask
  task automatic sc_crc();
    run(6'h09, 32'h0, 1, 11'h000, 1, K_C);
    run(6'h09, 32'h0, 2, 11'h000, 0, K_S);
    CRC_CHECK_EN = 1'b0;
    run(6'h09, 32'h0, 1, 11'h080, 1, K_S);
  endtask
  task automatic sc_other();
    run(6'h18, 32'hcafe0001, 0, 11'h001, 0, K_S);
    chk(OTHER_INDEX, 6'h18);
    chk(OTHER_ARG, 32'hcafe0001);
    chk(CMD_CLASSES, 12'h1f5);
  endtask
  initial begin
    RST_N = 1'b0;
    CRC_CHECK_EN = 1'b1;
    BLOCK_SENT = 1'b0;
    host.pulse(4);
    @(posedge CLK);
    #1 RST_N = 1'b1;
    host.pulse(4);
    @(posedge CLK);
    #1;
    sc_basic();
    sc_illegal();
    sc_blocks();
    sc_multi();
    sc_switch();
    sc_crc();
    sc_other();
    complete_run();
  end
endmodule
`default_nettype wire
